/* hw/char_lcd_instruction_decoder.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Code bits 2..0 become pattern RAM address bits 5..3, eight patterns.
// - Pattern address bits 2..0 pick the row; row 8 ORed with cursor.
// - Ones in row 8 light pixels regardless of cursor presence.
// - Row pixels come from data bits 4..0, bit 4 leftmost.
// - Codes with bits 7..4 zero fetch a pattern; bit 3 ignored.
// - A pattern bit of one lights the pixel, zero leaves it off.
// - Usable pattern RAM size follows the character ROM option.
// - Order select high: icon address bits map ascending to segments.
// - Order select low: icon mapping reversed, 00H bit 4 highest.
// - Normal instruction set decoded only with extension option high.
// - Clear fills text RAM with 20H, address counter to 00H, long time.
// - Home sets address counter 00H, undoes shift, text kept.
// - Entry mode stores direction and shift for later data accesses.
// - Cursor/display shift moves cursor or display one position.
// - Function set picks bus width and line count.
// - Set pattern address loads 6 bits, targets pattern RAM.
// - Set text address loads 7 bits, targets text RAM.
// - Command read returns busy on bit 7, counter on bits 6..0.
// - Data write stores at counter target then steps counter.
// - Data read returns byte at counter then steps counter.
// - Three-line option picks 80 segments, else 100 segments.
// - Clear also forces entry mode to increment.
module char_lcd_instruction_decoder #(
  parameter int CYC_LONG_P  = lcd_pkg::CYC_LONG,
  parameter int CYC_SHORT_P = lcd_pkg::CYC_SHORT
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        extension_table_option,
  input  wire logic        segment_order_sel,
  input  wire logic        three_line_option,
  input  wire logic        char_rom_option,
  output logic             busy_flag,
  output logic             disp_on,
  output logic             cursor_on,
  output logic             blink_on,
  output logic             bus_width_sel,
  output logic             two_line
);
  // Straps may move at any time relative to hclk, so every reader sees
  // them only after two flops; a strap change takes effect two clocks late
  // and software should let it settle before relying on it.
  // Option pins are straps from outside: two-stage sync
  logic [3:0] opt_s1_q, opt_s2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_s1_q <= 4'h0;
      opt_s2_q <= 4'h0;
    end else begin
      opt_s1_q <= {extension_table_option, segment_order_sel,
                   three_line_option, char_rom_option};
      opt_s2_q <= opt_s1_q;
    end
  end
  wire ext_ok   = opt_s2_q[3];
  wire seg_asc  = opt_s2_q[2];
  wire n3       = opt_s2_q[1];
  wire rom_half = opt_s2_q[0];

  // Storage
  logic [7:0] text_q [lcd_pkg::TEXT_DEPTH];
  logic [7:0] pat_q  [lcd_pkg::PAT_DEPTH];
  logic [7:0] icon_q [lcd_pkg::ICON_DEPTH];
  logic [6:0] ac_q, ac_d;
  logic [6:0] shift_q;
  lcd_pkg::target_t tgt_q;
  lcd_pkg::entry_t  entry_q;
  lcd_pkg::onoff_t  onoff_q;
  lcd_pkg::func_t   func_q;
  logic [20:0] busy_cnt_q;
  logic        clearing_q;
  logic [6:0]  clr_idx_q;

  // AHB address phase capture
  logic       dph_q, dwr_q;
  logic [7:0] daddr_q;
  wire  take = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q   <= 1'b0;
      dwr_q   <= 1'b0;
      daddr_q <= 8'h00;
    end else begin
      dph_q   <= take;
      dwr_q   <= hwrite;
      daddr_q <= haddr[7:0];
    end
  end

  // Decode of the data phase
  wire        busy    = busy_cnt_q != 21'h0;
  wire        wr_cmd  = dph_q & dwr_q & (daddr_q == lcd_pkg::OFF_CMD);
  wire        wr_dat  = dph_q & dwr_q & (daddr_q == lcd_pkg::OFF_DATA);
  wire        rd_dat  = dph_q & ~dwr_q & (daddr_q == lcd_pkg::OFF_DATA);
  wire        wr_pix  = dph_q & dwr_q & (daddr_q == lcd_pkg::OFF_PIXQ);
  wire        wr_seg  = dph_q & dwr_q & (daddr_q == lcd_pkg::OFF_SEGQ);
  wire        cmd_go  = wr_cmd & ~busy & ext_ok;
  wire        dat_go  = (wr_dat | rd_dat) & ~busy;
  wire [7:0]  cmd     = hwdata[7:0];
  wire        is_clr  = cmd_go & (cmd == 8'h01);
  wire        is_home = cmd_go & (cmd[7:1] == 7'h01);
  wire        is_ent  = cmd_go & (cmd[7:2] == 6'h01);
  wire        is_onf  = cmd_go & (cmd[7:3] == 5'h01);
  wire        is_shf  = cmd_go & (cmd[7:4] == 4'h1);
  wire        is_fun  = cmd_go & (cmd[7:5] == 3'h1);
  wire        is_pat  = cmd_go & (cmd[7:6] == 2'h1);
  wire        is_txt  = cmd_go & cmd[7];
  wire        long_op = is_clr | is_home;

  // Counter step by entry mode, wrapped to the target's range
  wire [6:0] ac_step = entry_q.incr ? ac_q + 7'h01 : ac_q - 7'h01;
  wire [6:0] ac_wrap = (tgt_q == lcd_pkg::TGT_PAT) ? {1'b0, ac_step[5:0]} :
                       ac_step;
  // Pattern RAM half unused with this ROM option
  wire       pat_ok  = ~rom_half | ~ac_q[5];

  always_comb begin
    ac_d = ac_q;
    if (is_clr | is_home)
      ac_d = lcd_pkg::ADDR_HOME;
    else if (is_shf & ~cmd[3])
      ac_d = cmd[2] ? ac_q + 7'h01 : ac_q - 7'h01;
    else if (is_pat)
      ac_d = {1'b0, cmd[5:0]};
    else if (is_txt)
      ac_d = cmd[6:0];
    else if (dat_go)
      ac_d = ac_wrap;
  end

  // One counter times every command and data access; a new command or data access is
  // only accepted at zero, so a host that ignores busy simply loses it.
  // The long count must exceed the 128-clock clear sweep so the sweep ends before a new access is taken.
  // Control state and busy timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ac_q       <= 7'h00;
      shift_q    <= 7'h00;
      tgt_q      <= lcd_pkg::TGT_TEXT;
      entry_q    <= 2'b10;
      onoff_q    <= 3'b000;
      func_q     <= 2'b10;
      busy_cnt_q <= 21'h0;
      clearing_q <= 1'b0;
      clr_idx_q  <= 7'h00;
    end else begin
      ac_q <= ac_d;
      if (long_op)
        busy_cnt_q <= 21'(CYC_LONG_P);
      else if (cmd_go | dat_go)
        busy_cnt_q <= 21'(CYC_SHORT_P);
      else if (busy)
        busy_cnt_q <= busy_cnt_q - 21'h1;
      if (is_clr) begin
        clearing_q <= 1'b1;
        clr_idx_q  <= 7'h00;
        entry_q.incr <= 1'b1;
      end else if (clearing_q) begin
        clr_idx_q  <= clr_idx_q + 7'h01;
        clearing_q <= clr_idx_q != 7'h7f;
      end
      if (long_op)
        shift_q <= 7'h00;
      else if (is_shf & cmd[3])
        shift_q <= cmd[2] ? shift_q - 7'h01 : shift_q + 7'h01;
      else if (dat_go & wr_dat & entry_q.shift)
        shift_q <= entry_q.incr ? shift_q + 7'h01 : shift_q - 7'h01;
      if (is_ent)
        entry_q <= cmd[1:0];
      if (is_onf)
        onoff_q <= cmd[2:0];
      if (is_fun)
        func_q <= cmd[4:3];
      if (is_pat)
        tgt_q <= lcd_pkg::TGT_PAT;
      else if (is_txt | long_op)
        tgt_q <= lcd_pkg::TGT_TEXT;
    end
  end

  // RAM writes; clear sweeps one text location per clock
  always_ff @(posedge hclk) begin
    if (clearing_q)
      text_q[clr_idx_q] <= lcd_pkg::CODE_SPACE;
    else if (dat_go & wr_dat & (tgt_q == lcd_pkg::TGT_TEXT))
      text_q[ac_q] <= hwdata[7:0];
    if (dat_go & wr_dat & (tgt_q == lcd_pkg::TGT_PAT) & pat_ok)
      pat_q[ac_q[5:0]] <= hwdata[7:0];
    if (wr_seg & ~busy & (ac_q <= lcd_pkg::ICON_LAST))
      icon_q[ac_q[3:0]] <= hwdata[7:0];
  end

  // Pixel query: code, row, cursor flag give five pixel bits
  logic [11:0] pixq_q;
  logic [6:0]  segq_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pixq_q <= 12'h000;
      segq_q <= 7'h00;
    end else begin
      if (wr_pix)
        pixq_q <= hwdata[11:0];
      if (wr_seg)
        segq_q <= hwdata[14:8];
    end
  end
  wire [7:0] q_code  = pixq_q[7:0];
  wire [2:0] q_row   = pixq_q[10:8];
  wire       q_cur   = pixq_q[11];
  wire       q_user  = q_code[7:4] == 4'h0;
  wire [5:0] q_paddr = {q_code[2:0], q_row};
  wire [4:0] q_row_d = pat_q[q_paddr][4:0];
  wire       q_curow = q_cur & (q_row == lcd_pkg::LAST_ROW);
  wire [4:0] q_pix   = q_user ? (q_row_d | {5{q_curow}}) : 5'h00;

  // With 100 segments, segments 1..20 and 81..100 share the first four icon
  // bytes, so one icon bit lights two segments; software must accept the
  // pairing, as the icon store holds only sixteen bytes.
  // Segment query: segment number 1..N to icon address and bit
  wire [6:0] seg_n   = n3 ? 7'(lcd_pkg::SEG_N3) :
                            7'(lcd_pkg::SEG_MAX);
  wire [6:0] s0      = segq_q - 7'h01;
  wire [6:0] s_fold  = (~n3 & (s0 >= 7'd80)) ? s0 - 7'd80 : s0;
  wire [6:0] s_rev   = (n3 ? 7'd79 : 7'd99) - s0;
  wire [6:0] s_rfold = (~n3 & (s_rev >= 7'd80)) ? s_rev - 7'd80 : s_rev;
  wire [6:0] s_idx   = seg_asc ? s_fold : s_rfold;
  wire [3:0] s_addr  = 4'(s_idx / 7'd5);
  wire [2:0] s_bit   = 3'(7'd4 - (s_idx % 7'd5));
  wire       s_valid = (segq_q != 7'h00) & (segq_q <= seg_n);
  wire       s_on    = s_valid & icon_q[s_addr][s_bit];

  // Read mux
  wire [7:0] ram_rd  = (tgt_q == lcd_pkg::TGT_PAT) ? pat_q[ac_q[5:0]] :
                       text_q[ac_q];
  wire       rd_next = take & ~hwrite;
  wire [7:0] ra      = haddr[7:0];
  wire [31:0] rd_mux =
    (ra == lcd_pkg::OFF_CMD)    ? {24'h0, busy, ac_q} :
    (ra == lcd_pkg::OFF_DATA)   ? {24'h0, ram_rd} :
    (ra == lcd_pkg::OFF_CFG)    ? {24'h0, 1'b0, onoff_q, func_q, entry_q} :
    (ra == lcd_pkg::OFF_STATUS) ? {25'h0, shift_q} :
    (ra == lcd_pkg::OFF_PIXR)   ? {27'h0, q_pix} :
    (ra == lcd_pkg::OFF_SEGR)   ? {31'h0, s_on} : 32'h0;

  // Outputs from flops; zero-wait OKAY slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata        <= 32'h0;
      busy_flag     <= 1'b0;
      disp_on       <= 1'b0;
      cursor_on     <= 1'b0;
      blink_on      <= 1'b0;
      bus_width_sel <= 1'b1;
      two_line      <= 1'b0;
    end else begin
      if (rd_next)
        hrdata <= rd_mux;
      busy_flag     <= busy;
      disp_on       <= onoff_q.disp_on;
      cursor_on     <= onoff_q.cursor_on;
      blink_on      <= onoff_q.blink_on;
      bus_width_sel <= func_q.width8;
      two_line      <= func_q.two_line;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  a_busy_long: assert property (@(posedge hclk) disable iff (!hresetn)
    long_op |=> busy [*8]) else $error("long op not busy");
  a_clr_home: assert property (@(posedge hclk) disable iff (!hresetn)
    is_clr |=> ac_q == 7'h00 && entry_q.incr) else $error("clear");
  a_ignore_busy: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cmd && busy |=> $stable(entry_q) && $stable(onoff_q))
    else $error("cmd taken while busy");
  a_set_text: assert property (@(posedge hclk) disable iff (!hresetn)
    is_txt |=> ac_q == $past(cmd[6:0]) && tgt_q == lcd_pkg::TGT_TEXT)
    else $error("text addr");
  a_set_pat: assert property (@(posedge hclk) disable iff (!hresetn)
    is_pat |=> ac_q == {1'b0, $past(cmd[5:0])}) else $error("pat");
  a_step_up: assert property (@(posedge hclk) disable iff (!hresetn)
    dat_go && entry_q.incr && tgt_q == lcd_pkg::TGT_TEXT
    |=> ac_q == $past(ac_q) + 7'h01) else $error("step");
  a_pix_rom: assert property (@(posedge hclk) disable iff (!hresetn)
    q_code[7:4] != 4'h0 |-> q_pix == 5'h00) else $error("pix");
  a_pix_cursor: assert property (@(posedge hclk) disable iff (!hresetn)
    q_user && q_curow |-> q_pix == 5'h1f) else $error("cursor");
  a_ext_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !ext_ok |-> !cmd_go) else $error("ext");

  // Further guards on the instruction decode, the timer and the read path.
  // All but the status read and width output checks look at state one clock after
  // the triggering data phase, which is when the registered state shows the effect.

  // Short operations load the short execution count
  a_busy_short: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmd_go | dat_go) && !long_op |=> busy_cnt_q == 21'(CYC_SHORT_P))
    else $error("short busy count");

  // Data accesses while busy leave the counter where it was
  a_dat_refused: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_dat || rd_dat) && busy |=> ac_q == $past(ac_q))
    else $error("data taken while busy");

  // Home rewinds the counter and the display shift
  a_home_rewind: assert property (@(posedge hclk) disable iff (!hresetn)
    is_home |=> ac_q == lcd_pkg::ADDR_HOME && shift_q == 7'h00)
    else $error("home rewind");

  // Home starts no sweep, so text contents survive
  a_home_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    is_home |=> !clearing_q) else $error("home clears text");

  // Clear starts the sweep at the first location and targets text
  a_clear_sweep: assert property (@(posedge hclk) disable iff (!hresetn)
    is_clr |=> clearing_q && clr_idx_q == 7'h00 &&
    tgt_q == lcd_pkg::TGT_TEXT) else $error("clear sweep");

  // Entry mode keeps both bits of the instruction
  a_entry_store: assert property (@(posedge hclk) disable iff (!hresetn)
    is_ent |=> entry_q == $past(cmd[1:0]))
    else $error("entry mode");

  // Display control keeps all three enables
  a_onoff_store: assert property (@(posedge hclk) disable iff (!hresetn)
    is_onf |=> onoff_q == $past(cmd[2:0]))
    else $error("display control");

  // Function set keeps width and line count
  a_func_store: assert property (@(posedge hclk) disable iff (!hresetn)
    is_fun |=> func_q == $past(cmd[4:3]))
    else $error("function set");

  // Cursor move steps the counter by one in the chosen direction
  a_cursor_move: assert property (@(posedge hclk) disable iff (!hresetn)
    is_shf && !cmd[3] |=> ac_q == ($past(cmd[2]) ? $past(ac_q) + 7'h01 :
    $past(ac_q) - 7'h01)) else $error("cursor move");

  // Display shift leaves the counter alone
  a_shift_still: assert property (@(posedge hclk) disable iff (!hresetn)
    is_shf && cmd[3] |=> ac_q == $past(ac_q))
    else $error("display shift moved counter");

  // Pattern address switches the target to pattern RAM
  a_pat_target: assert property (@(posedge hclk) disable iff (!hresetn)
    is_pat |=> tgt_q == lcd_pkg::TGT_PAT) else $error("pat target");

  // Status read returns busy over the counter
  a_cmd_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_next && ra == lcd_pkg::OFF_CMD |=>
    hrdata[7:0] == {$past(busy), $past(ac_q)})
    else $error("status read");

  // Width output follows the stored width one clock later
  a_width_out: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 bus_width_sel == $past(func_q.width8))
    else $error("width output");
endmodule : char_lcd_instruction_decoder

/* inc/lcd_pkg.sv */
package lcd_pkg;
  // Register byte addresses (chosen)
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_CFG    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_PIXQ   = 8'h10;
  localparam logic [7:0] OFF_PIXR   = 8'h14;
  localparam logic [7:0] OFF_SEGQ   = 8'h18;
  localparam logic [7:0] OFF_SEGR   = 8'h1c;

  // Instruction constants
  localparam logic [7:0] CODE_SPACE = 8'h20;
  localparam logic [6:0] ADDR_HOME  = 7'h00;
  localparam int         TEXT_DEPTH = 128;
  localparam int         PAT_DEPTH  = 64;
  localparam int         ICON_DEPTH = 16;
  localparam logic [2:0] LAST_ROW   = 3'h7;
  localparam logic [6:0] ICON_LAST  = 7'h0f;
  localparam int         SEG_N3     = 80;
  localparam int         SEG_MAX    = 100;

  // Execution times at 380 kHz oscillator
  localparam real CLK_MHZ      = 100.0;
  localparam real T_SHORT_US   = 26.3;
  localparam real T_LONG_MS    = 1.08;
  localparam int  CYC_SHORT    = int'(T_SHORT_US * CLK_MHZ);
  localparam int  CYC_LONG     = int'(T_LONG_MS * 1000.0 * CLK_MHZ);

  typedef enum logic [1:0] {
    TGT_TEXT,
    TGT_PAT,
    TGT_ICON
  } target_t;

  typedef struct packed {
    logic incr;
    logic shift;
  } entry_t;

  typedef struct packed {
    logic disp_on;
    logic cursor_on;
    logic blink_on;
  } onoff_t;

  typedef struct packed {
    logic width8;
    logic two_line;
  } func_t;
endpackage : lcd_pkg

/* sim/lcd_host.sv */
`timescale 1ns/1ps
// Host processor model: single-word transfers with busy polling
module lcd_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Address phase held until hready, data phase until hready again
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d; // Stale data never looks valid
  endtask : xfer

  // Never issue while the busy flag still reads one
  task automatic poll();
    logic [31:0] q;
    q = 32'h80;
    // Polling replaces any fixed wait, so no execution time is assumed
    while (q[7] !== 1'b0) xfer(1'b0, lcd_pkg::OFF_CMD, 32'h0, q);
  endtask : poll

  // Polled instruction or data byte
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    logic [31:0] q;
    poll();
    xfer(1'b1, a, {24'h0, b}, q);
  endtask : put
endmodule : lcd_host

/* sim/char_lcd_instruction_decoder_bench.sv */
`timescale 1ns/1ps
module char_lcd_instruction_decoder_bench;
  localparam int SHORT_C = 20;
  logic        hclk, hresetn, ext_opt, order_sel, three_line, rom_opt;
  logic        hsel, hwrite, hready, hresp, busy, dsp, cur, blk, bw, tl;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          n_fail, checks_done, cycles;

  // Shortened execution counts keep the run brief
  char_lcd_instruction_decoder #(.CYC_LONG_P(300), .CYC_SHORT_P(SHORT_C))
    char_lcd_instruction_decoder_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .extension_table_option(ext_opt), .segment_order_sel(order_sel),
    .three_line_option(three_line), .char_rom_option(rom_opt),
    .busy_flag(busy), .disp_on(dsp), .cursor_on(cur), .blink_on(blk),
    .bus_width_sel(bw), .two_line(tl));

  lcd_host lcd_host_inst (
    .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // Clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Bus helpers: plain read, polled counter read, polled command write
  task automatic rd(input logic [7:0] a);
    lcd_host_inst.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic ac_is(input logic [7:0] e);
    lcd_host_inst.poll();
    rd(lcd_pkg::OFF_CMD);
    chk({24'h0, q[7:0]}, {24'h0, e});
  endtask : ac_is
  task automatic cmd(input logic [7:0] b);
    lcd_host_inst.put(lcd_pkg::OFF_CMD, b);
  endtask : cmd

  // Clear after a decrementing write: fill, home, increment, busy
  task automatic t_clear();
    cmd(8'h04);
    cmd(8'h85);
    lcd_host_inst.put(lcd_pkg::OFF_DATA, 8'h41);
    ac_is(8'h04);
    cmd(8'h01);
    repeat (3) @(posedge hclk);
    chk({31'h0, busy}, 32'h1);
    ac_is(8'h00);
    rd(lcd_pkg::OFF_CFG);
    chk({31'h0, q[1]}, 32'h1);
    cmd(8'h85);
    lcd_host_inst.poll();
    rd(lcd_pkg::OFF_DATA);
    chk({24'h0, q[7:0]}, {24'h0, lcd_pkg::CODE_SPACE});
  endtask : t_clear

  // Display control, function set, cursor shift, home with bit 0 set
  task automatic t_ctrl();
    cmd(8'h0f);
    lcd_host_inst.poll();
    chk({29'h0, dsp, cur, blk}, 32'h7);
    cmd(8'h20);
    lcd_host_inst.poll();
    chk({30'h0, bw, tl}, 32'h0);
    cmd(8'h38);
    lcd_host_inst.poll();
    chk({30'h0, bw, tl}, 32'h3);
    cmd(8'h85);
    cmd(8'h14);
    ac_is(8'h06);
    cmd(8'h03);
    ac_is(8'h00);
  endtask : t_ctrl

  task automatic pix(input logic [7:0] c, input logic [2:0] r,
                     input logic k, input logic [4:0] e);
    lcd_host_inst.xfer(1'b1, lcd_pkg::OFF_PIXQ, {20'h0, k, r, c}, q);
    rd(lcd_pkg::OFF_PIXR);
    chk({27'h0, q[4:0]}, {27'h0, e});
  endtask : pix

  // Pattern 1 rows; upper data bits must not show
  task automatic t_pat();
    cmd(8'h48);
    for (int i = 0; i < 8; i++)
      lcd_host_inst.put(lcd_pkg::OFF_DATA,
                        i == 0 ? 8'hea : (i == 7 ? 8'h04 : 8'h11));
    ac_is(8'h10);
    pix(8'h01, 3'h0, 1'b0, 5'h0a);
    pix(8'h09, 3'h0, 1'b0, 5'h0a);
    pix(8'h01, 3'h1, 1'b0, 5'h11);
    pix(8'h01, 3'h7, 1'b0, 5'h04);
    pix(8'h09, 3'h7, 1'b1, 5'h1f);
    // Upper pattern half is dropped on writes with the ROM option high
    cmd(8'h60);
    lcd_host_inst.put(lcd_pkg::OFF_DATA, 8'h15);
    rom_opt <= 1'b1;
    repeat (3) @(posedge hclk);
    cmd(8'h60);
    lcd_host_inst.put(lcd_pkg::OFF_DATA, 8'h0a);
    cmd(8'h60);
    lcd_host_inst.poll();
    rd(lcd_pkg::OFF_DATA);
    chk({24'h0, q[7:0]}, 32'h15);
    rom_opt <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : t_pat

  // Strap change, then segment query with icon byte 00H = bit 4 only
  task automatic seg(input logic o, input logic t, input logic [6:0] n,
                     input logic e);
    @(posedge hclk);
    order_sel  <= o;
    three_line <= t;
    repeat (3) @(posedge hclk);
    lcd_host_inst.poll();
    lcd_host_inst.xfer(1'b1, lcd_pkg::OFF_SEGQ, {17'h0, n, 8'h10}, q);
    rd(lcd_pkg::OFF_SEGR);
    chk({31'h0, q[0]}, {31'h0, e});
  endtask : seg

  task automatic t_icon();
    cmd(8'h80);
    seg(1'b1, 1'b1, 7'd1, 1'b1);
    seg(1'b1, 1'b1, 7'd2, 1'b0);
    seg(1'b1, 1'b0, 7'd81, 1'b1);
    seg(1'b0, 1'b0, 7'd100, 1'b1);
    seg(1'b0, 1'b1, 7'd80, 1'b1);
    seg(1'b0, 1'b1, 7'd79, 1'b0);
  endtask : t_icon

  // Commands while busy, and with the normal table disabled, are dropped
  task automatic t_refuse();
    cmd(8'h90);
    rd(lcd_pkg::OFF_CMD);
    chk({24'h0, q[7:0]}, 32'h90);
    lcd_host_inst.xfer(1'b1, lcd_pkg::OFF_CMD, 32'ha0, q);
    ac_is(8'h10);
    ext_opt <= 1'b0;
    repeat (3) @(posedge hclk);
    lcd_host_inst.xfer(1'b1, lcd_pkg::OFF_CMD, 32'hb0, q);
    repeat (SHORT_C + 5) @(posedge hclk);
    ext_opt <= 1'b1;
    repeat (3) @(posedge hclk);
    ac_is(8'h10);
  endtask : t_refuse

  // Hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      end_sim();
    end
  end

  // Main sequence
  initial begin
    hresetn = 1'b0;
    ext_opt = 1'b1;
    order_sel = 1'b1;
    three_line = 1'b1;
    rom_opt = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({25'h0, busy, dsp, cur, blk, bw, tl, hresp}, 32'h4);
    t_clear();
    t_ctrl();
    t_pat();
    t_icon();
    t_refuse();
    end_sim();
  end
endmodule : char_lcd_instruction_decoder_bench
